/* File: rtl/jss_consts.vh */
// constants for the jog/slack setpoint selector
`ifndef JSS_CONSTS_VH
`define JSS_CONSTS_VH
// register byte offsets
`define JSS_OFF_PERMIT 8'h00
`define JSS_OFF_DOUT 8'h04
`define JSS_OFF_LVL_A 8'h08
`define JSS_OFF_LVL_B 8'h0c
`define JSS_OFF_JOG1 8'h10
`define JSS_OFF_JOG2 8'h14
`define JSS_OFF_TAKE1 8'h18
`define JSS_OFF_TAKE2 8'h1c
`define JSS_OFF_CRAWL 8'h20
`define JSS_OFF_MODE 8'h24
`define JSS_OFF_INCH 8'h28
`define JSS_OFF_RAMPIN 8'h2c
`define JSS_OFF_STATUS 8'h30
`define JSS_OFF_SPDOUT 8'h34
`define JSS_OFF_CRAWLSEL 8'h38
// bit positions
`define JSS_BIT_RUN 0
`define JSS_BIT_JOG 1
`define JSS_BIT_EN 2
`define JSS_BIT_JOGACT 3
`define JSS_BIT_SLACK 4
`define JSS_BIT_CRAWL 5
// percent values in hundredths, 16-bit signed
`define JSS_PCT_MAX 16'sh2710
`define JSS_PCT_MIN -16'sh2710
`define JSS_RST_PERMIT 3'h7
`define JSS_RST_DOUT 3'h0
`define JSS_RST_LVL 16'h0000
`define JSS_RST_JOG1 16'h01f4
`define JSS_RST_JOG2 16'hfe0c
`define JSS_RST_TAKE1 16'h01f4
`define JSS_RST_TAKE2 16'hfe0c
`define JSS_RST_CRAWL 16'h03e8
`define JSS_RST_MODE 1'b0
// inch ramp time in tenths of a second
`define JSS_INCH_MIN 16'h0001
`define JSS_INCH_MAX 16'h1770
`define JSS_RST_INCH 16'h000a
// crawl decode: bit index = {mode, jog, run}; default crawl on mode only
`define JSS_RST_CRAWLSEL 8'h10
`define JSS_SCURVE_ZERO 16'h0000
`endif

/* File: rtl/jss_sync.v */
// three-stage synchroniser with agreement filter for a pin level
module jss_sync (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // change counts only once stages two and three agree
      if (s2_ff == s3_ff) begin
        q_o <= s3_ff;
      end
    end
  end
endmodule

/* File: rtl/jss_clamp.v */
// saturating clamp of a signed percent value to +/-100.00
`include "jss_consts.vh"
module jss_clamp (
  input wire signed [16:0] d_i,
  output wire [15:0] q_o
);
  wire signed [16:0] hi;
  wire signed [16:0] lo;
  assign hi = {1'b0, `JSS_PCT_MAX};
  assign lo = {1'b1, `JSS_PCT_MIN};
  assign q_o = (d_i > hi) ? hi[15:0] : (d_i < lo) ? lo[15:0] : d_i[15:0];
endmodule

/* File: rtl/jss_top.v */
// aux i/o gate and jog/slack setpoint selector with wishbone registers
//
// Contract
// RULE_01 - effective run, jog, enable are terminal input AND host permit
// RULE_02 - permit bits reset ON so terminals act alone
// RULE_03 - host drives three discrete outputs and two clamped level outputs
// RULE_04 - gated run, jog, enable go to start, enable and selector
// RULE_05 - jog with run off replaces demand by jog setpoint
// RULE_06 - mode bit picks jog setpoint 1 or 2 while jogging
// RULE_07 - jogging uses inch ramp time both ways, s-curve forced zero
// RULE_08 - inch ramp time 0.1 to 600.0 s, resets to 1.0 s
// RULE_09 - jog while running adds take-up-slack setpoint to demand
// RULE_10 - mode and jog choose which take-up setpoint is added; code picks take-up 1 or 2 by the mode bit alone
// RULE_11 - crawl mode outputs crawl setpoint instead of demand
// RULE_12 - jog setpoints within 100 percent, reset 5.00 and -5.00
// RULE_13 - take-up setpoints within 100 percent, reset 5.00 and -5.00
// RULE_14 - mode bit resets false and steers all setpoint choices
// RULE_15 - output feeds shaping ramp, input from ramp input stage
// RULE_16 - clamped ramp input is modified before shaping
// RULE_17 - otherwise demand passes unchanged with normal ramp settings
// RULE_18 - crawl condition is a configurable decode of run, jog, mode
`include "jss_consts.vh"
module jss_top (
  input wire clk_i,
  input wire rst_i,
  input wire [31:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  output reg err_o,
  input wire term_run_i,
  input wire term_jog_i,
  input wire term_enable_i,
  input wire term_mode_i,
  input wire [15:0] ramp_demand_i,
  input wire [15:0] normal_accel_time_i,
  input wire [15:0] normal_decel_time_i,
  input wire [15:0] normal_scurve_i,
  output reg start_run_o,
  output reg start_jog_o,
  output reg drive_enable_o,
  output reg host_discrete_out_a_o,
  output reg host_discrete_out_b_o,
  output reg host_discrete_out_c_o,
  output reg [15:0] host_level_out_a_o,
  output reg [15:0] host_level_out_b_o,
  output reg [15:0] shaped_demand_o,
  output reg [15:0] accel_time_o,
  output reg [15:0] decel_time_o,
  output reg [15:0] scurve_o,
  output reg jogging_o
);

////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire run_s;
  wire jog_s;
  wire en_s;
  wire mode_pin_s;
  jss_sync u_sync_run (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(term_run_i),
    .q_o(run_s)
  );
  jss_sync u_sync_jog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(term_jog_i),
    .q_o(jog_s)
  );
  jss_sync u_sync_en (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(term_enable_i),
    .q_o(en_s)
  );
  jss_sync u_sync_mode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(term_mode_i),
    .q_o(mode_pin_s)
  );

////////////////////////////////////////////////////////////////////////////////
  // registers
  reg [2:0] permit_ff;
  reg [2:0] dout_ff;
  reg [15:0] lvl_a_ff;
  reg [15:0] lvl_b_ff;
  reg [15:0] jog1_ff;
  reg [15:0] jog2_ff;
  reg [15:0] take1_ff;
  reg [15:0] take2_ff;
  reg [15:0] crawl_ff;
  reg mode_ff;
  reg [15:0] inch_ramp_time_ff;
  reg [7:0] crawlsel_ff;

  wire req;
  wire wr;
  wire [7:0] off;
  wire hit;
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr = req & we_i;
  assign off = adr_i[7:0];
  assign hit = (adr_i[31:8] == 24'h000000) && (off[1:0] == 2'b00) &&
               (off <= `JSS_OFF_CRAWLSEL);

  // 16-bit fields sit in the low half of the write word
  wire [15:0] wdat16;
  assign wdat16 = dat_i[15:0];

  // clamp written signed percent values to the legal span
  wire [15:0] wpct;
  jss_clamp u_wclamp (
    .d_i({wdat16[15], wdat16}),
    .q_o(wpct)
  );

  // limit written inch ramp time; out-of-range writes saturate
  wire [15:0] winch;
  assign winch = (wdat16 < `JSS_INCH_MIN) ? `JSS_INCH_MIN :
                 (wdat16 > `JSS_INCH_MAX) ? `JSS_INCH_MAX : wdat16;

  wire wfull;
  assign wfull = wr & hit & (sel_i[1:0] == 2'b11);

  // one strobe per register; byte fields need lane 0 only
  wire wbyte;
  wire wr_permit;
  wire wr_dout;
  wire wr_mode;
  wire wr_crawlsel;
  wire wr_lvl_a;
  wire wr_lvl_b;
  wire wr_jog1;
  wire wr_jog2;
  wire wr_take1;
  wire wr_take2;
  wire wr_crawl;
  wire wr_inch;
  assign wbyte = wr & hit & sel_i[0];
  assign wr_permit = wbyte & (off == `JSS_OFF_PERMIT);
  assign wr_dout = wbyte & (off == `JSS_OFF_DOUT);
  assign wr_mode = wbyte & (off == `JSS_OFF_MODE);
  assign wr_crawlsel = wbyte & (off == `JSS_OFF_CRAWLSEL);
  assign wr_lvl_a = wfull & (off == `JSS_OFF_LVL_A);
  assign wr_lvl_b = wfull & (off == `JSS_OFF_LVL_B);
  assign wr_jog1 = wfull & (off == `JSS_OFF_JOG1);
  assign wr_jog2 = wfull & (off == `JSS_OFF_JOG2);
  assign wr_take1 = wfull & (off == `JSS_OFF_TAKE1);
  assign wr_take2 = wfull & (off == `JSS_OFF_TAKE2);
  assign wr_crawl = wfull & (off == `JSS_OFF_CRAWL);
  assign wr_inch = wfull & (off == `JSS_OFF_INCH);

  always @(posedge clk_i) begin
    if (rst_i) begin
      permit_ff <= `JSS_RST_PERMIT; // RULE_02
      dout_ff <= `JSS_RST_DOUT; // RULE_03
      lvl_a_ff <= `JSS_RST_LVL;
      lvl_b_ff <= `JSS_RST_LVL;
      jog1_ff <= `JSS_RST_JOG1; // RULE_12
      jog2_ff <= `JSS_RST_JOG2;
      take1_ff <= `JSS_RST_TAKE1; // RULE_13
      take2_ff <= `JSS_RST_TAKE2;
      crawl_ff <= `JSS_RST_CRAWL;
      mode_ff <= `JSS_RST_MODE; // RULE_14
      inch_ramp_time_ff <= `JSS_RST_INCH; // RULE_08
      crawlsel_ff <= `JSS_RST_CRAWLSEL;
    end else begin
      if (wr_permit) begin
        permit_ff <= dat_i[2:0]; // RULE_01
      end
      if (wr_dout) begin
        dout_ff <= dat_i[2:0]; // RULE_03
      end
      if (wr_mode) begin
        mode_ff <= dat_i[0]; // RULE_14
      end
      if (wr_crawlsel) begin
        crawlsel_ff <= dat_i[7:0]; // RULE_18
      end
      // 16-bit values need both low lanes to avoid torn updates
      if (wr_lvl_a) begin
        lvl_a_ff <= wpct; // RULE_03
      end
      if (wr_lvl_b) begin
        lvl_b_ff <= wpct;
      end
      if (wr_jog1) begin
        jog1_ff <= wpct; // RULE_12
      end
      if (wr_jog2) begin
        jog2_ff <= wpct;
      end
      if (wr_take1) begin
        take1_ff <= wpct; // RULE_13
      end
      if (wr_take2) begin
        take2_ff <= wpct;
      end
      if (wr_crawl) begin
        crawl_ff <= wpct;
      end
      if (wr_inch) begin
        inch_ramp_time_ff <= winch; // RULE_08
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // aux gate
  wire run_g;
  wire jog_g;
  wire en_g;
  wire mode_eff;
  assign run_g = run_s & permit_ff[`JSS_BIT_RUN]; // RULE_01
  assign jog_g = jog_s & permit_ff[`JSS_BIT_JOG]; // RULE_01
  assign en_g = en_s & permit_ff[`JSS_BIT_EN]; // RULE_01
  // software mode bit or spare pin; either may set the mode
  assign mode_eff = mode_ff | mode_pin_s; // RULE_14

////////////////////////////////////////////////////////////////////////////////
  // jog/slack selector
  wire crawl_sel;
  wire jog_sel;
  wire slack_sel;
  // crawl decode indexed by {mode, jog, run}
  assign crawl_sel = crawlsel_ff[{mode_eff, jog_g, run_g}]; // RULE_18
  assign jog_sel = jog_g & ~run_g & ~crawl_sel; // RULE_05
  assign slack_sel = jog_g & run_g & ~crawl_sel; // RULE_09

  wire [15:0] take_pick;
  wire [15:0] jog_pick;
  assign jog_pick = mode_eff ? jog2_ff : jog1_ff; // RULE_06
  assign take_pick = mode_eff ? take2_ff : take1_ff; // RULE_10

  // demand arrives already min-speed clamped from ramp input stage
  wire [16:0] slack_sum;
  wire [15:0] slack_sat;
  assign slack_sum = {ramp_demand_i[15], ramp_demand_i} +
                     {take_pick[15], take_pick}; // RULE_09 RULE_16
  jss_clamp u_sclamp (
    .d_i(slack_sum),
    .q_o(slack_sat)
  );

  reg [15:0] nxt_spd;
  always @* begin
    if (crawl_sel) begin
      nxt_spd = crawl_ff; // RULE_11
    end else if (jog_sel) begin
      nxt_spd = jog_pick; // RULE_05
    end else if (slack_sel) begin
      nxt_spd = slack_sat; // RULE_09
    end else begin
      nxt_spd = ramp_demand_i; // RULE_17
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      start_run_o <= 1'b0;
      start_jog_o <= 1'b0;
      drive_enable_o <= 1'b0;
      host_discrete_out_a_o <= 1'b0;
      host_discrete_out_b_o <= 1'b0;
      host_discrete_out_c_o <= 1'b0;
      host_level_out_a_o <= `JSS_RST_LVL;
      host_level_out_b_o <= `JSS_RST_LVL;
      shaped_demand_o <= 16'h0000;
      accel_time_o <= 16'h0000;
      decel_time_o <= 16'h0000;
      scurve_o <= `JSS_SCURVE_ZERO;
      jogging_o <= 1'b0;
    end else begin
      start_run_o <= run_g; // RULE_04
      start_jog_o <= jog_g; // RULE_04
      drive_enable_o <= en_g; // RULE_04
      host_discrete_out_a_o <= dout_ff[0]; // RULE_03
      host_discrete_out_b_o <= dout_ff[1];
      host_discrete_out_c_o <= dout_ff[2];
      host_level_out_a_o <= lvl_a_ff; // RULE_03
      host_level_out_b_o <= lvl_b_ff;
      shaped_demand_o <= nxt_spd; // RULE_15
      jogging_o <= jog_sel;
      if (jog_sel) begin
        accel_time_o <= inch_ramp_time_ff; // RULE_07
        decel_time_o <= inch_ramp_time_ff; // RULE_07
        scurve_o <= `JSS_SCURVE_ZERO; // RULE_07
      end else begin
        accel_time_o <= normal_accel_time_i; // RULE_17
        decel_time_o <= normal_decel_time_i;
        scurve_o <= normal_scurve_i;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // wishbone read and acknowledge; one wait state per access
  reg [31:0] nxt_rd;
  always @* begin
    nxt_rd = 32'h00000000;
    case (off)
      `JSS_OFF_PERMIT: nxt_rd[2:0] = permit_ff;
      `JSS_OFF_DOUT: nxt_rd[2:0] = dout_ff;
      `JSS_OFF_LVL_A: nxt_rd[15:0] = lvl_a_ff;
      `JSS_OFF_LVL_B: nxt_rd[15:0] = lvl_b_ff;
      `JSS_OFF_JOG1: nxt_rd[15:0] = jog1_ff;
      `JSS_OFF_JOG2: nxt_rd[15:0] = jog2_ff;
      `JSS_OFF_TAKE1: nxt_rd[15:0] = take1_ff;
      `JSS_OFF_TAKE2: nxt_rd[15:0] = take2_ff;
      `JSS_OFF_CRAWL: nxt_rd[15:0] = crawl_ff;
      `JSS_OFF_MODE: nxt_rd[0] = mode_ff;
      `JSS_OFF_INCH: nxt_rd[15:0] = inch_ramp_time_ff;
      `JSS_OFF_RAMPIN: nxt_rd[15:0] = ramp_demand_i;
      `JSS_OFF_STATUS: nxt_rd[5:0] = {crawl_sel, slack_sel, jog_sel,
                                      en_g, jog_g, run_g};
      `JSS_OFF_SPDOUT: nxt_rd[15:0] = shaped_demand_o;
      `JSS_OFF_CRAWLSEL: nxt_rd[7:0] = crawlsel_ff;
      default: nxt_rd = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      dat_o <= (req & hit & ~we_i) ? nxt_rd : 32'h00000000;
    end
  end
endmodule

/* File: bench/jss_top_chk.sv */
// port assertions for the jog/slack selector
module jss_top_chk (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire err_o,
  input wire [31:0] dat_o,
  input wire term_run_i,
  input wire term_jog_i,
  input wire term_enable_i,
  input wire [15:0] normal_accel_time_i,
  input wire [15:0] normal_scurve_i,
  input wire start_run_o,
  input wire start_jog_o,
  input wire drive_enable_o,
  input wire [15:0] host_level_out_a_o,
  input wire [15:0] accel_time_o,
  input wire [15:0] decel_time_o,
  input wire [15:0] scurve_o,
  input wire jogging_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  // 8 cycles cover the pin filter plus the output flop
  run_gate_a: assert property ((!term_run_i)[*8] |-> !start_run_o)
    else $error("run out high with pin low");
  jog_gate_a: assert property ((!term_jog_i)[*8] |-> !start_jog_o)
    else $error("jog out high with pin low");
  en_gate_a: assert property (
    (!term_enable_i)[*8] |-> !drive_enable_o)
    else $error("enable out high with pin low");
  jog_ramp_a: assert property (jogging_o |-> scurve_o == 16'h0000 &&
    accel_time_o == decel_time_o) else $error("jog ramp not applied");
  // two edges skipped: outputs are still zero just after reset
  normal_ramp_a: assert property (!jogging_o && !$past(rst_i) &&
    !$past(rst_i, 2) |-> accel_time_o == $past(normal_accel_time_i) &&
    scurve_o == $past(normal_scurve_i)) else $error("normal ramp lost");
  level_lim_a: assert property (
    $signed(host_level_out_a_o) <= 16'sh2710 &&
    $signed(host_level_out_a_o) >= -16'sh2710) else $error("level out range");
  bus_ans_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=>
    ack_o ^ err_o) else $error("no single answer");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
endmodule
bind jss_top jss_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .dat_o(dat_o),
  .term_run_i(term_run_i), .term_jog_i(term_jog_i),
  .term_enable_i(term_enable_i), .normal_accel_time_i(normal_accel_time_i),
  .normal_scurve_i(normal_scurve_i), .start_run_o(start_run_o),
  .start_jog_o(start_jog_o), .drive_enable_o(drive_enable_o),
  .host_level_out_a_o(host_level_out_a_o), .accel_time_o(accel_time_o),
  .decel_time_o(decel_time_o), .scurve_o(scurve_o), .jogging_o(jogging_o));

/* File: bench/jss_host.sv */
// wishbone host model standing in for the serial-link controller
module jss_host (
  input wire clk_i,
  input wire ack_i,
  input wire err_i,
  output logic cyc_o = 1'b0,
  output logic stb_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [3:0] sel_o = 4'h0,
  output logic [31:0] adr_o = 32'h0,
  output logic [31:0] dat_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // released bus shows inverted values so stale data cannot pass as valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    sel_o <= 4'hf;
    adr_o <= {24'h0, a};
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~{24'h0, a};
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

/* File: bench/jss_top_tb.sv */
// self-checking bench for the jog/slack setpoint selector
`include "jss_consts.vh"
module jss_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, look = 1'b0, mreg = 1'b0;
  logic tr = 1'b0, tj = 1'b0, te = 1'b0, tm = 1'b0;
  logic [15:0] dem = 16'h0, na = 16'h0064, nd = 16'h0064, ns = 16'h0;
  logic [15:0] la = 16'h0, lb = 16'h0, js1 = `JSS_RST_JOG1, inch = 16'h000a;
  logic [2:0] perm = 3'h7, dout = 3'h0;
  logic [7:0] csel = `JSS_RST_CRAWLSEL;
  logic [16:0] bus_q [$];
  logic [102:0] st_q [$];
  int err_total = 0, samples_checked = 0, cyc_cnt = 0, seed = 32'h12af;
  logic [7:0] adrs [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h38};
  logic [15:0] rv [12] = '{16'h0007, 16'h0000, 16'h0000, 16'h0000,
    16'h01f4, 16'hfe0c, 16'h01f4, 16'hfe0c, 16'h03e8, 16'h0000, 16'h000a,
    16'h0010};
  logic [2:0] pt [4] = '{3'h7, 3'h0, 3'h5, 3'h7};
  wire cyc, stb, we, ack, err;
  wire [3:0] sel;
  wire [31:0] adr, wdat, rdat;
  wire [102:0] st;
  always #20 clk_i = ~clk_i;
  jss_host u_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));
  jss_top u_jss_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack), .err_o(err), .term_run_i(tr), .term_jog_i(tj),
    .term_enable_i(te), .term_mode_i(tm), .ramp_demand_i(dem),
    .normal_accel_time_i(na), .normal_decel_time_i(nd), .normal_scurve_i(ns),
    .start_run_o(st[102]), .start_jog_o(st[101]), .drive_enable_o(st[100]),
    .jogging_o(st[99]), .host_discrete_out_a_o(st[96]),
    .host_discrete_out_b_o(st[97]), .host_discrete_out_c_o(st[98]),
    .shaped_demand_o(st[95:80]), .accel_time_o(st[79:64]),
    .decel_time_o(st[63:48]), .scurve_o(st[47:32]),
    .host_level_out_a_o(st[31:16]), .host_level_out_b_o(st[15:0]));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [102:0] model();
    logic rg, jg, mo, cr, js, sl;
    logic [15:0] t, o;
    logic signed [16:0] s;
    rg = tr & perm[0];
    jg = tj & perm[1];
    mo = tm | mreg;
    cr = csel[{mo, jg, rg}];
    js = !cr & jg & !rg;
    sl = !cr & jg & rg;
    t = mo ? `JSS_RST_TAKE2 : `JSS_RST_TAKE1;
    s = $signed({dem[15], dem}) + $signed({t[15], t});
    if (s > `JSS_PCT_MAX) s = `JSS_PCT_MAX;
    if (s < `JSS_PCT_MIN) s = `JSS_PCT_MIN;
    o = cr ? `JSS_RST_CRAWL : js ? (mo ? `JSS_RST_JOG2 : js1) :
      sl ? s[15:0] : dem;
    return {rg, jg, te & perm[2], js, dout, o, js ? inch : na,
      js ? inch : nd, js ? 16'h0000 : ns, la, lb};
  endfunction
  task automatic tally(input logic bad, input logic [102:0] g, e);
    samples_checked++;
    if (bad) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [16:0] g, e);
    tally(g !== e, 103'(g), 103'(e));
  endtask
  task automatic cmp_st(input logic [102:0] g, e);
    tally(g !== e, g, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [16:0] e);
    bus_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic chk();
    st_q.push_back(model());
    @(posedge clk_i) look <= 1'b1;
    @(posedge clk_i) look <= 1'b0;
  endtask
  // settle time covers the pin filter and the output flop
  task automatic drive(input logic [3:0] k);
    @(posedge clk_i);
    {tm, te, tj, tr} <= k;
    dem <= 16'($random(seed) % 10001);
    na <= 16'({$random(seed)} % 6000 + 1);
    nd <= 16'({$random(seed)} % 6000 + 1);
    ns <= 16'({$random(seed)} % 10001);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if ((ack || err) && !we) cmp_bus({err, rdat[15:0]}, bus_q.pop_front());
    if (look) cmp_st(st, st_q.pop_front());
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) rd(adrs[i], {1'b0, rv[i]});
    rd(8'h3c, 17'h10000);
    chk();
    $display("test reset_map done");
    for (int c = 0; c < 4; c++) begin
      perm = pt[c];
      mreg = (c == 3);
      u_host.xfer(1'b1, `JSS_OFF_PERMIT, {29'h0, perm});
      u_host.xfer(1'b1, `JSS_OFF_MODE, {31'h0, mreg});
      for (int k = 0; k < 16; k++) begin
        drive(k[3:0]);
        chk();
      end
    end
    $display("test selector done");
    {dout, la, lb, js1, inch} = {3'h5, 16'h2710, 16'hd8f0, 16'hd8f0, 16'h1};
    u_host.xfer(1'b1, `JSS_OFF_DOUT, 32'h5);
    u_host.xfer(1'b1, `JSS_OFF_LVL_A, 32'h4e20);
    u_host.xfer(1'b1, `JSS_OFF_LVL_B, 32'hd8f0);
    u_host.xfer(1'b1, `JSS_OFF_JOG1, 32'h8000);
    u_host.xfer(1'b1, `JSS_OFF_INCH, 32'h0);
    mreg = 1'b0;
    u_host.xfer(1'b1, `JSS_OFF_MODE, 32'h0);
    rd(`JSS_OFF_JOG1, 17'h0d8f0);
    rd(`JSS_OFF_INCH, 17'h00001);
    drive(4'h2);
    chk();
    inch = 16'h1770;
    u_host.xfer(1'b1, `JSS_OFF_INCH, 32'h1b58);
    rd(`JSS_OFF_INCH, 17'h01770);
    drive(4'h6);
    chk();
    $display("test host_outputs done");
    csel = 8'h08;
    u_host.xfer(1'b1, `JSS_OFF_CRAWLSEL, 32'h8);
    rd(`JSS_OFF_CRAWLSEL, 17'h00008);
    drive(4'h3);
    chk();
    drive(4'h8);
    chk();
    $display("test crawl_decode done");
    finish_test();
  end
endmodule
